// *** shared/clk_mode_pkg.sv ***
// constants, types and decode helpers for the cpu clock mode selector
`default_nettype none
package clk_mode_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_LATCH  = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WINDOW = 8'h0C;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int          SEL_LSB      = 5;
  localparam int          SEL_MSB      = 7;
  localparam logic [7:0]  LATCH_RESET  = 8'h00;
  localparam logic [2:0]  GAIN_RESET   = 3'h1;
  localparam logic [2:0]  CODE_DIRECT  = 3'h3;
  localparam logic [2:0]  CODE_PRESCL  = 3'h1;
  localparam int          ST_LOCK_BIT  = 0;
  localparam int          ST_MODE_LSB  = 1;

  typedef enum {MODE_PLL, MODE_PRESCALE, MODE_DIRECT} mode_t;
  typedef enum {ST_RESET, ST_CAPTURE, ST_RUN} start_t;

  // ----------------------------------------
  // decode of the clock source select code
  // ----------------------------------------
  function automatic mode_t mode_of(input logic [2:0] code);
    case (code)
      CODE_DIRECT: mode_of = MODE_DIRECT;
      CODE_PRESCL: mode_of = MODE_PRESCALE;
      default:     mode_of = MODE_PLL;
    endcase
  endfunction

  // oscillator transitions per resync window
  function automatic logic [2:0] span_of(input logic [2:0] code);
    case (code)
      3'h7:    span_of = 3'h4;
      3'h6:    span_of = 3'h3;
      3'h5:    span_of = 3'h2;
      3'h4:    span_of = 3'h5;
      3'h2:    span_of = 3'h2;
      3'h0:    span_of = 3'h2;
      default: span_of = 3'h0;
    endcase
  endfunction

  // cpu clock phases per window: span x factor
  function automatic logic [4:0] phases_of(input logic [2:0] code);
    case (code)
      3'h7:    phases_of = 5'h10;
      3'h6:    phases_of = 5'h09;
      3'h5:    phases_of = 5'h04;
      3'h4:    phases_of = 5'h19;
      3'h2:    phases_of = 5'h03;
      3'h0:    phases_of = 5'h05;
      default: phases_of = 5'h00;
    endcase
  endfunction

endpackage
`default_nettype wire

// *** src/osc_window_meter.sv ***
// oscillator edge detection and resync window length measurement
`default_nettype none
module osc_window_meter #(
  parameter int WIN_W = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // oscillator and window span
  input  wire logic             osc_in,
  input  wire logic [2:0]       span,
  // edges and window results
  output logic                  osc_q,
  output logic                  osc_rise,
  output logic                  osc_fall,
  output logic                  win_done,
  output logic [WIN_W-1:0]      win_len
);
  import clk_mode_pkg::*;

  // ----------------------------------------
  // transition and cycle counting
  // ----------------------------------------
  logic [2:0]       trans_cnt;
  logic [WIN_W-1:0] cyc_cnt;
  logic [2:0]       next_trans_cnt;
  logic [WIN_W-1:0] next_cyc_cnt;
  logic             next_win_done;
  logic [WIN_W-1:0] next_win_len;
  logic             edge_now;

  always_comb begin
    edge_now       = osc_in ^ osc_q;
    next_win_done  = 1'b0;
    next_win_len   = win_len;
    next_trans_cnt = trans_cnt;
    // saturate so a stopped oscillator cannot wrap the count
    next_cyc_cnt   = (&cyc_cnt) ? cyc_cnt : cyc_cnt + 1'b1;
    if (span == 3'h0) begin
      next_trans_cnt = 3'h0;
      next_cyc_cnt   = '0;
    end else if (edge_now) begin
      if (trans_cnt == span - 3'h1) begin
        next_win_done  = 1'b1;
        next_win_len   = next_cyc_cnt;
        next_trans_cnt = 3'h0;
        next_cyc_cnt   = '0;
      end else begin
        next_trans_cnt = trans_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q     <= 1'b0;
      osc_rise  <= 1'b0;
      osc_fall  <= 1'b0;
      win_done  <= 1'b0;
      win_len   <= '0;
      trans_cnt <= 3'h0;
      cyc_cnt   <= '0;
    end else begin
      osc_q     <= osc_in;
      osc_rise  <= osc_in & ~osc_q;
      osc_fall  <= ~osc_in & osc_q;
      win_done  <= next_win_done;
      win_len   <= next_win_len;
      trans_cnt <= next_trans_cnt;
      cyc_cnt   <= next_cyc_cnt;
    end
  end

endmodule
`default_nettype wire

// *** src/cpu_clock_mode_select.sv ***
// cpu clock generation from the oscillator, mode strapped at long reset
//
// Implementation choices: the register offsets and the address-and-strobe port.
`default_nettype none
module cpu_clock_mode_select #(
  parameter int WIN_W  = 16,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // strap and oscillator
  input  wire logic [7:0]         port0_upper_byte,
  input  wire logic               oscillator_clock,
  // register port
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [31:0]             rdata,
  // cpu clock
  output logic                    cpu_clock,
  output logic                    cpu_clock_rise,
  output logic                    cpu_clock_fall,
  output logic [2:0]              clock_source_select,
  output logic                    pll_locked
);
  import clk_mode_pkg::*;

  // ----------------------------------------
  // startup and strap latch
  // ----------------------------------------
  start_t     state;
  start_t     next_state;
  logic [7:0] reset_config_latch_high;
  logic [7:0] next_latch;
  mode_t      mode;
  logic [2:0] span;
  logic [4:0] phases;

  always_comb begin
    next_state = state;
    next_latch = reset_config_latch_high;
    case (state)
      ST_RESET: next_state = ST_CAPTURE;
      ST_CAPTURE: begin
        next_latch = port0_upper_byte;
        next_state = ST_RUN;
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                   <= ST_RESET;
      reset_config_latch_high <= LATCH_RESET;
    end else begin
      state                   <= next_state;
      reset_config_latch_high <= next_latch;
    end
  end

  assign mode   = mode_of(reset_config_latch_high[SEL_MSB:SEL_LSB]);
  assign span   = (state == ST_RUN && mode == MODE_PLL)
                  ? span_of(reset_config_latch_high[SEL_MSB:SEL_LSB]) : 3'h0;
  assign phases = phases_of(reset_config_latch_high[SEL_MSB:SEL_LSB]);

  // ----------------------------------------
  // oscillator measurement
  // ----------------------------------------
  logic             osc_q;
  logic             osc_rise;
  logic             osc_fall;
  logic             win_done;
  logic [WIN_W-1:0] win_len;

  osc_window_meter #(.WIN_W(WIN_W)) u_meter (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .osc_in   (oscillator_clock),
    .span     (span),
    .osc_q    (osc_q),
    .osc_rise (osc_rise),
    .osc_fall (osc_fall),
    .win_done (win_done),
    .win_len  (win_len)
  );

  // ----------------------------------------
  // clock generator
  // ----------------------------------------
  // output toggles at most once per ref_clk, so cpu_clock must stay
  // at or below half the ref_clk rate
  logic [2:0]       gain;
  logic [WIN_W:0]   acc;
  logic [WIN_W-1:0] win_used;
  logic [4:0]       toggle_cnt;
  logic [4:0]       last_toggles;
  logic             steady;
  logic [WIN_W:0]   next_acc;
  logic [WIN_W-1:0] next_win_used;
  logic [4:0]       next_toggle_cnt;
  logic [4:0]       next_last_toggles;
  logic             next_steady;
  logic             next_cpu_clock;
  logic             next_locked;
  logic             toggle;
  logic [WIN_W:0]   diff;
  logic [WIN_W:0]   step;
  logic [WIN_W:0]   sum;

  always_comb begin
    next_win_used     = win_used;
    next_toggle_cnt   = toggle_cnt;
    next_last_toggles = last_toggles;
    next_steady       = steady;
    next_locked       = pll_locked;
    next_acc          = acc;
    toggle            = 1'b0;
    diff              = {1'b0, win_len} - {1'b0, win_used};
    step              = $signed(diff) >>> gain;
    sum               = '0;
    if (win_done) begin
      if (win_used == '0 || gain == 3'h0) begin
        next_win_used = win_len;
      end else if (step == '0 && diff != '0) begin
        next_win_used = diff[WIN_W] ? win_used - 1'b1 : win_used + 1'b1;
      end else begin
        next_win_used = win_used + step[WIN_W-1:0];
      end
    end
    if (mode == MODE_PLL && span != 3'h0 && next_win_used != '0) begin
      sum = (win_done ? '0 : acc) + {{(WIN_W-4){1'b0}}, phases};
      if (sum >= {1'b0, next_win_used}) begin
        toggle   = 1'b1;
        next_acc = sum - {1'b0, next_win_used};
      end else begin
        next_acc = sum;
      end
    end
    if (win_done) begin
      next_last_toggles = toggle_cnt;
      next_toggle_cnt   = {4'h0, toggle};
      next_steady       = 1'b1;
      next_locked       = steady && (toggle_cnt == phases);
    end else if (toggle) begin
      next_toggle_cnt = toggle_cnt + 5'h01;
    end
    case (mode)
      MODE_PLL:      next_cpu_clock = cpu_clock ^ toggle;
      MODE_PRESCALE: next_cpu_clock = cpu_clock ^ (osc_rise && state == ST_RUN);
      // straight pass, two phases = one period
      MODE_DIRECT:   next_cpu_clock = (state == ST_RUN) ? osc_q : 1'b0;
      default:       next_cpu_clock = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc            <= '0;
      win_used       <= '0;
      toggle_cnt     <= 5'h00;
      last_toggles   <= 5'h00;
      steady         <= 1'b0;
      pll_locked     <= 1'b0;
      cpu_clock      <= 1'b0;
      cpu_clock_rise <= 1'b0;
      cpu_clock_fall <= 1'b0;
    end else begin
      acc            <= next_acc;
      win_used       <= next_win_used;
      toggle_cnt     <= next_toggle_cnt;
      last_toggles   <= next_last_toggles;
      steady         <= next_steady;
      pll_locked     <= next_locked;
      cpu_clock      <= next_cpu_clock;
      // a phase unit starts on either edge
      cpu_clock_rise <= next_cpu_clock & ~cpu_clock;
      cpu_clock_fall <= ~next_cpu_clock & cpu_clock;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic [2:0]  next_gain;
  logic [31:0] next_rdata;

  always_comb begin
    next_gain  = gain;
    next_rdata = 32'h0000_0000;
    if (wr && addr == ADDR_W'(ADDR_CTRL)) begin
      next_gain = wdata[2:0];
    end
    if (rd) begin
      case (addr)
        ADDR_W'(ADDR_LATCH):  next_rdata = {24'h00_0000, reset_config_latch_high};
        ADDR_W'(ADDR_CTRL):   next_rdata = {29'h0, gain};
        ADDR_W'(ADDR_STATUS): next_rdata = {24'h00_0000, last_toggles,
                                            mode == MODE_PRESCALE,
                                            mode == MODE_DIRECT, pll_locked};
        ADDR_W'(ADDR_WINDOW): next_rdata = {{(32-WIN_W){1'b0}}, win_used};
        default:              next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain                <= GAIN_RESET;
      rdata               <= 32'h0000_0000;
      clock_source_select <= 3'h0;
    end else begin
      gain                <= next_gain;
      rdata               <= next_rdata;
      clock_source_select <= next_latch[SEL_MSB:SEL_LSB];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_strap_capture;
    @(posedge ref_clk) disable iff (!rst_n)
    state == ST_CAPTURE |=> reset_config_latch_high == $past(port0_upper_byte);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("strap not captured into config latch");

  property p_pll_count;
    @(posedge ref_clk) disable iff (!rst_n)
    win_done && steady && win_used == win_len && phases <= win_used
      |-> toggle_cnt == phases;
  endproperty
  a_pll_count: assert property (p_pll_count)
    else $error("pll phase count per window wrong");

  property p_prescale;
    @(posedge ref_clk) disable iff (!rst_n)
    mode == MODE_PRESCALE && state == ST_RUN
      |=> cpu_clock == ($past(cpu_clock) ^ $past(osc_rise));
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler did not follow oscillator rise");

  property p_direct;
    @(posedge ref_clk) disable iff (!rst_n)
    mode == MODE_DIRECT && state == ST_RUN |=> cpu_clock == $past(osc_q);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct drive does not follow oscillator");

  property p_gradual;
    @(posedge ref_clk) disable iff (!rst_n)
    win_done && win_used != '0 && gain != 3'h0 && win_len > win_used
      |=> win_used > $past(win_used) && win_used <= $past(win_len);
  endproperty
  a_gradual: assert property (p_gradual)
    else $error("pll window adjust not gradual");

  property p_edges;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(cpu_clock) |-> cpu_clock_rise ##1 !cpu_clock_rise;
  endproperty
  a_edges: assert property (p_edges)
    else $error("cpu clock rise not marked");

  // pulse is registered beside the level, so it stands in the same cycle
  property p_fall;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(cpu_clock) |-> cpu_clock_fall ##1 !cpu_clock_fall;
  endproperty
  a_fall: assert property (p_fall)
    else $error("cpu clock fall not marked");

  property p_direct_period;
    @(posedge ref_clk) disable iff (!rst_n)
    mode == MODE_DIRECT && state == ST_RUN ##1 osc_rise |=> cpu_clock_rise;
  endproperty
  a_direct_period: assert property (p_direct_period)
    else $error("direct drive period not tied to oscillator");

  property p_mode_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    state == ST_RUN |=> $stable(reset_config_latch_high) && state == ST_RUN;
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("clock mode changed while running");

  c_pll_lock: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pll_locked));
  c_prescale: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mode == MODE_PRESCALE && cpu_clock_fall);
  c_direct: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mode == MODE_DIRECT && cpu_clock_rise);
  c_window: cover property (@(posedge ref_clk) disable iff (!rst_n)
    win_done && pll_locked && win_used == win_len);

endmodule
`default_nettype wire

// *** bench/osc_strap_model.sv ***
// oscillator and strap pin model facing the cpu clock selector
`default_nettype none
module osc_strap_model (
  // clock
  input  wire logic       ref_clk,
  // wave shape and strap levels
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  input  wire logic [7:0] strap,
  // pins
  output logic            oscillator_clock,
  output logic [7:0]      port0_upper_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial oscillator_clock = 1'b0;
  // free running; uneven duty lets direct drive show odd phases
  always @(posedge ref_clk) begin
    cnt <= cnt + 1;
    if (cnt + 1 >= int'(oscillator_clock ? hi_len : lo_len)) begin
      cnt <= 0;
      oscillator_clock <= ~oscillator_clock;
    end
  end
  assign port0_upper_byte = strap;
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the cpu clock mode selector
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        cpu_clock;
  logic        cpu_clock_rise;
  logic        cpu_clock_fall;
  logic [2:0]  clock_source_select;
  logic        pll_locked;
  logic        oscillator_clock;
  logic [7:0]  port0_upper_byte;
  logic [7:0]  strap = 8'hE0;
  logic [7:0]  hi_len = 8'h14;
  logic [7:0]  lo_len = 8'h14;
  int          failures = 0;
  int          checks_done = 0;
  int          seed = 32'h312cb398;
  int          tog;
  int          pul;
  int          cyc;
  int          ph[$];
  logic        last;
  bit          mon = 1'b0;

  always #50 ref_clk = ~ref_clk;

  cpu_clock_mode_select dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .port0_upper_byte(port0_upper_byte),
    .oscillator_clock(oscillator_clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cpu_clock(cpu_clock), .cpu_clock_rise(cpu_clock_rise),
    .cpu_clock_fall(cpu_clock_fall), .clock_source_select(clock_source_select),
    .pll_locked(pll_locked)
  );

  osc_strap_model osc (
    .ref_clk(ref_clk), .hi_len(hi_len), .lo_len(lo_len), .strap(strap),
    .oscillator_clock(oscillator_clock), .port0_upper_byte(port0_upper_byte)
  );

  // ----------------------------------------
  // bench model: phase lengths and edge pulses
  // ----------------------------------------
  always @(negedge ref_clk) begin
    if (mon) begin
      cyc++;
      if (cpu_clock !== last) begin
        ph.push_back(cyc);
        cyc = 0;
        tog++;
      end
      if (cpu_clock_rise === 1'b1 || cpu_clock_fall === 1'b1) pul++;
    end
    last = cpu_clock;
  end

  // oscillator transitions per resync window
  function automatic int win_span(input logic [2:0] c);
    case (c)
      3'h7:    return 4;
      3'h6:    return 3;
      3'h4:    return 5;
      default: return 2;
    endcase
  endfunction

  // cpu phases per window, span times factor
  function automatic int win_phases(input logic [2:0] c);
    case (c)
      3'h7:    return 16;
      3'h6:    return 9;
      3'h5:    return 4;
      3'h4:    return 25;
      3'h2:    return 3;
      3'h0:    return 5;
      default: return 0;
    endcase
  endfunction

  // ----------------------------------------
  // compares, bus cycles, closing
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_len(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask

  // long reset with a strap code, then check what was caught
  task automatic start(input logic [2:0] c, output logic [7:0] lat);
    logic [31:0] v;
    lat = {c, 5'($random(seed))};
    @(posedge ref_clk);
    rst_n  <= 1'b0;
    strap  <= lat;
    hi_len <= (c == 3'h3) ? 8'h0F : 8'h14;
    lo_len <= (c == 3'h3) ? 8'h19 : 8'h14;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_reg({29'h0, clock_source_select}, {29'h0, c});
    rd_reg(8'h00, v);
    chk_reg(v, {24'h0, lat});
    rd_reg(8'h04, v);
    chk_reg(v, 32'h1);
    rd_reg(8'h08, v);
    chk_reg(v & 32'h7, {29'h0, c == 3'h1, c == 3'h3, 1'b0});
  endtask

  // ----------------------------------------
  // main sequence: every strap code in turn
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [31:0] d;
    logic [7:0]  lat;
    int          n;
    int          expt;
    for (int c = 0; c < 8; c++) begin
      start(3'(c), lat);
      if (c == 2) begin
        wr_reg(8'h04, 32'h0);
        rd_reg(8'h04, v);
        chk_reg(v, 32'h0);
      end
      if (c != 1 && c != 3) begin
        for (n = 0; n < 8000 && pll_locked !== 1'b1; n++) @(negedge ref_clk);
        if (n == 8000) begin
          failures++;
          $display("ERROR %0t lock wait ran out", $time);
          wrap_up();
        end
      end
      ph.delete();
      tog = 0;
      pul = 0;
      cyc = 0;
      mon = 1'b1;
      repeat (1200) @(negedge ref_clk);
      mon = 1'b0;
      // 1200 cycles hold whole osc periods and whole windows
      expt = (c == 3) ? 60 : (c == 1) ? 30 : win_phases(3'(c)) * 60 / win_span(3'(c));
      chk_len((tog - expt) * (tog - expt) <= 1, 1);
      chk_len((tog - pul) * (tog - pul) <= 1, 1);
      for (int i = 1; i + 1 < ph.size(); i++) begin
        if (c == 3) chk_len(ph[i] + ph[i+1], 40);
        else if (c == 1) chk_len(ph[i], 40);
      end
      if (c != 1 && c != 3) begin
        rd_reg(8'h08, v);
        chk_reg({27'h0, v[7:3]}, 32'(win_phases(3'(c))));
        chk_reg({31'h0, v[0]}, 32'h1);
        rd_reg(8'h0C, v);
        chk_reg(v, 32'(win_span(3'(c)) * 20));
      end
      @(posedge ref_clk);
      strap <= ~strap;
      repeat (4) @(negedge ref_clk);
      chk_reg({29'h0, clock_source_select}, {29'h0, 3'(c)});
      rd_reg(8'h00, v);
      chk_reg(v, {24'h0, lat});
    end
    // register port: control readback, read-only latch, unmapped hole
    d = $random(seed);
    wr_reg(8'h04, d);
    rd_reg(8'h04, v);
    chk_reg(v, {29'h0, d[2:0]});
    wr_reg(8'h00, d);
    rd_reg(8'h00, v);
    chk_reg(v, {24'h0, lat});
    rd_reg(8'h10, v);
    chk_reg(v, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
